//--- rtl/rss_reset_sequencer.v
// reset source combiner, cause flags and start-up sequencer
// Overview of operation
// R1: low supply holds reset, flags brown-out
// R2: one brown-out flag for both detectors
// R3: use low-power detector only when standard off
// R4: config bit enables low-power detector; erased off
// R5: pin reset off only if both bits zero
// R6: low external pin holds reset; pulled up
// R7: filter ignores short low pin pulses
// R8: device never drives the pin low
// R9: pin disabled: plain input, software pull-up
// R10: watchdog time-out resets, clears time-out flag; power-down unchanged
// R11: window violation recorded in own flag
// R12: software reset instruction clears its flag
// R13: stack fault resets when enabled, sets flag
// R14: programming exit behaves like power-on
// R15: optional power-up timer after power-on/brown-out
// R16: run needs timer done and pin released
// R17: power-up timer runs independent of pin
// R18: pin release after timer: run ten cycles later
// R19: time-out and power-down flag values
// R20: sources combined, released synchronously
`timescale 1ns/1ps
`default_nettype none
`include "rss_consts.vh"
module rss_reset_sequencer #(
    parameter [`RSS_CNT_W-1:0] PUT_CYCLES = `RSS_PUT_CYCLES
) (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       por_i,
    input  wire       brownout_i,
    input  wire       low_power_brownout_i,
    input  wire [1:0] brownout_enable_setting_i,
    input  wire       low_power_brownout_cfg_i,
    input  wire       cfg_erased_i,
    input  wire       ext_reset_pin_i,
    input  wire       ext_reset_pin_enable_i,
    input  wire       low_voltage_program_enable_i,
    input  wire       gpio_pullup_sw_i,
    input  wire       watchdog_timeout_i,
    input  wire       watchdog_window_viol_i,
    input  wire       watchdog_clear_instr_i,
    input  wire       sleep_instr_i,
    input  wire       software_reset_instr_i,
    input  wire       stack_overflow_i,
    input  wire       stack_underflow_i,
    input  wire       stack_fault_reset_enable_i,
    input  wire       prog_mode_exit_i,
    input  wire       powerup_timer_enable_n_i,
    input  wire       brownout_flag_clr_i,
    input  wire       software_reset_flag_set_i,
    input  wire       stack_flags_clr_i,
    input  wire       window_flag_set_i,
    output reg        core_reset_o,
    output reg        ext_pin_oe_o,
    output reg        ext_pin_pullup_o,
    output reg        ext_pin_gpio_o,
    output reg        low_power_brownout_config_ok_o,
    output reg        brownout_reset_flag_o,
    output reg        timeout_flag_o,
    output reg        powerdown_flag_o,
    output reg        watchdog_window_violation_flag_o,
    output reg        software_reset_flag_o,
    output reg        stack_overflow_flag_o,
    output reg        stack_underflow_flag_o
);
    localparam [1:0] ST_HOLD  = 2'h0;
    localparam [1:0] ST_WAIT  = 2'h1;
    localparam [1:0] ST_DELAY = 2'h2;
    localparam [1:0] ST_RUN   = 2'h3;

    reg  [1:0] state_r;
    reg  [1:0] state_nxt;
    reg  [3:0] dly_r;
    reg  [3:0] dly_nxt;
    reg        put_start_r;
    wire       pin_low;
    wire       put_done;
    wire       pin_en;
    wire       low_power_brownout_en;
    wire       power_evt;
    wire       wdt_rst;
    wire       stk_rst;
    wire       pin_rst;
    wire       any_rst;

    // only a disabled or sleep-off standard detector suits the low-power one
    function cfg_ok;
        input [1:0] setting;
        begin
            cfg_ok = (setting == `RSS_BOR_FULL_OFF) || (setting == `RSS_BOR_SLEEP_OFF); // R3
        end
    endfunction

    assign pin_en    = ext_reset_pin_enable_i | low_voltage_program_enable_i; // R5
    assign low_power_brownout_en  = low_power_brownout_cfg_i & ~cfg_erased_i; // R4
    assign power_evt = por_i | brownout_i | (low_power_brownout_en & low_power_brownout_i) | prog_mode_exit_i; // R1 R14
    assign wdt_rst   = watchdog_timeout_i | watchdog_window_viol_i;
    assign stk_rst   = stack_fault_reset_enable_i & (stack_overflow_i | stack_underflow_i); // R13
    assign pin_rst   = pin_en & pin_low; // R6
    assign any_rst   = power_evt | wdt_rst | stk_rst | software_reset_instr_i | pin_rst; // R20

    rss_pin_filter u_filt (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i (ext_reset_pin_i),
        .low_o (pin_low)
    );

    rss_startup_timer #(
        .PUT_CYCLES (PUT_CYCLES)
    ) u_put (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (put_start_r),
        .enable_i (~powerup_timer_enable_n_i),
        .done_o   (put_done)
    );

    // timer restarts only from power events; the pin never touches it
    always @(posedge clk_i) begin
        if (rst_i) begin
            put_start_r <= 1'h1;
        end else begin
            put_start_r <= power_evt; // R17
        end
    end

    always @* begin
        state_nxt = state_r;
        dly_nxt   = dly_r;
        case (state_r)
            ST_HOLD: begin
                if (!any_rst) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (any_rst) begin
                    state_nxt = ST_HOLD;
                end else if (put_done && !pin_rst) begin // R16
                    state_nxt = ST_DELAY;
                    dly_nxt   = 4'h0;
                end
            end
            ST_DELAY: begin
                if (any_rst) begin
                    state_nxt = ST_HOLD;
                end else if (dly_r == `RSS_START_OSC_CYCLES - 1) begin // R18
                    state_nxt = ST_RUN;
                end else begin
                    dly_nxt = dly_r + 4'h1;
                end
            end
            ST_RUN: begin
                if (any_rst) begin
                    state_nxt = ST_HOLD;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
    end

    // reset leaves only through the clocked state machine, so release is synchronous
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r      <= ST_HOLD;
            dly_r        <= 4'h0;
            core_reset_o <= 1'h1;
        end else begin
            state_r      <= state_nxt;
            dly_r        <= dly_nxt;
            core_reset_o <= (state_nxt != ST_RUN) | any_rst; // R20
        end
    end

    // pin is input only; pull-up forced on while the reset function owns it
    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_pin_oe_o      <= 1'h0;
            ext_pin_pullup_o  <= 1'h1;
            ext_pin_gpio_o    <= 1'h0;
            low_power_brownout_config_ok_o <= 1'h1;
        end else begin
            ext_pin_oe_o      <= 1'h0; // R8
            ext_pin_pullup_o  <= pin_en | gpio_pullup_sw_i; // R6 R9
            ext_pin_gpio_o    <= ~pin_en; // R9
            low_power_brownout_config_ok_o <= ~low_power_brownout_en | cfg_ok(brownout_enable_setting_i);
        end
    end

    // reset events win over software writes in the same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            brownout_reset_flag_o            <= `RSS_FLAG_CLR;
            timeout_flag_o                   <= `RSS_FLAG_SET;
            powerdown_flag_o                 <= `RSS_FLAG_SET;
            watchdog_window_violation_flag_o <= `RSS_FLAG_SET;
            software_reset_flag_o            <= `RSS_FLAG_SET;
            stack_overflow_flag_o            <= `RSS_FLAG_CLR;
            stack_underflow_flag_o           <= `RSS_FLAG_CLR;
        end else begin
            if (brownout_i || (low_power_brownout_en && low_power_brownout_i)) begin
                brownout_reset_flag_o <= `RSS_FLAG_CLR; // R1 R2
            end else if (por_i || prog_mode_exit_i) begin
                brownout_reset_flag_o <= `RSS_FLAG_CLR;
            end else if (brownout_flag_clr_i) begin
                brownout_reset_flag_o <= `RSS_FLAG_SET;
            end
            if (por_i || prog_mode_exit_i) begin
                timeout_flag_o   <= `RSS_FLAG_SET; // R19
                powerdown_flag_o <= `RSS_FLAG_SET;
            end else if (watchdog_timeout_i) begin
                timeout_flag_o   <= `RSS_FLAG_CLR; // R10
            end else if (watchdog_clear_instr_i) begin
                timeout_flag_o   <= `RSS_FLAG_SET; // R19
                powerdown_flag_o <= `RSS_FLAG_SET;
            end else if (sleep_instr_i) begin
                timeout_flag_o   <= `RSS_FLAG_SET;
                powerdown_flag_o <= `RSS_FLAG_CLR;
            end
            if (watchdog_window_viol_i) begin
                watchdog_window_violation_flag_o <= `RSS_FLAG_CLR; // R11
            end else if (window_flag_set_i) begin
                watchdog_window_violation_flag_o <= `RSS_FLAG_SET;
            end
            if (software_reset_instr_i) begin
                software_reset_flag_o <= `RSS_FLAG_CLR; // R12
            end else if (software_reset_flag_set_i) begin
                software_reset_flag_o <= `RSS_FLAG_SET;
            end
            if (stack_fault_reset_enable_i && stack_overflow_i) begin
                stack_overflow_flag_o <= `RSS_FLAG_SET; // R13
            end else if (stack_flags_clr_i) begin
                stack_overflow_flag_o <= `RSS_FLAG_CLR;
            end
            if (stack_fault_reset_enable_i && stack_underflow_i) begin
                stack_underflow_flag_o <= `RSS_FLAG_SET; // R13
            end else if (stack_flags_clr_i) begin
                stack_underflow_flag_o <= `RSS_FLAG_CLR;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/rss_consts.vh
// constants for the reset source sequencer
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH
`define RSS_CLK_MHZ            100
`define RSS_PUT_TIME_US        64
`define RSS_PUT_CYCLES         (`RSS_PUT_TIME_US * `RSS_CLK_MHZ)
`define RSS_START_OSC_CYCLES   10
`define RSS_FILT_CYCLES        4
`define RSS_BOR_FULL_OFF       2'h0
`define RSS_BOR_SLEEP_OFF      2'h2
`define RSS_FLAG_SET           1'h1
`define RSS_FLAG_CLR           1'h0
`define RSS_CNT_W              16
`define RSS_FILT_W             4
`endif

//--- rtl/rss_pin_filter.v
// three-stage synchroniser and low-pulse filter for the external reset pin
`timescale 1ns/1ps
`default_nettype none
`include "rss_consts.vh"
module rss_pin_filter (
    input  wire clk_i,
    input  wire rst_i,
    input  wire pin_i,
    output reg  low_o
);
    reg                   s1_r;
    reg                   s2_r;
    reg                   s3_r;
    reg [`RSS_FILT_W-1:0] cnt_r;

    // stage one feeds only stage two
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 1'h1;
            s2_r <= 1'h1;
            s3_r <= 1'h1;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a low shorter than the filter length never reaches low_o
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= {`RSS_FILT_W{1'h0}};
            low_o <= 1'h0;
        end else if (!s2_r && !s3_r) begin
            if (cnt_r == `RSS_FILT_CYCLES) begin // R7
                low_o <= 1'h1;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end else if (s2_r && s3_r) begin
            cnt_r <= {`RSS_FILT_W{1'h0}};
            low_o <= 1'h0;
        end
    end
endmodule
`default_nettype wire

//--- rtl/rss_startup_timer.v
// power-up timer: counts from its start pulse, independent of the pin
`timescale 1ns/1ps
`default_nettype none
`include "rss_consts.vh"
module rss_startup_timer #(
    parameter [`RSS_CNT_W-1:0] PUT_CYCLES = `RSS_PUT_CYCLES
) (
    input  wire clk_i,
    input  wire rst_i,
    input  wire start_i,
    input  wire enable_i,
    output reg  done_o
);
    reg [`RSS_CNT_W-1:0] cnt_r;

    always @(posedge clk_i) begin
        if (rst_i || start_i) begin
            cnt_r  <= {`RSS_CNT_W{1'h0}};
            done_o <= 1'h0;
        end else if (!enable_i) begin
            done_o <= 1'h1;
        end else if (cnt_r == PUT_CYCLES - 16'h1) begin
            done_o <= 1'h1; // R15
        end else if (!done_o) begin
            cnt_r <= cnt_r + 16'h1;
        end
    end
endmodule
`default_nettype wire

//--- test/rss_reset_sequencer_asserts.sv
// port-level assertions for the reset source sequencer
`timescale 1ns/1ps
`default_nettype none
module rss_reset_sequencer_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic brownout_i,
    input wire logic low_power_brownout_i,
    input wire logic low_power_brownout_cfg_i,
    input wire logic cfg_erased_i,
    input wire logic ext_reset_pin_enable_i,
    input wire logic low_voltage_program_enable_i,
    input wire logic watchdog_timeout_i,
    input wire logic watchdog_window_viol_i,
    input wire logic software_reset_instr_i,
    input wire logic stack_overflow_i,
    input wire logic stack_fault_reset_enable_i,
    input wire logic core_reset_o,
    input wire logic ext_pin_oe_o,
    input wire logic ext_pin_pullup_o,
    input wire logic ext_pin_gpio_o,
    input wire logic brownout_reset_flag_o,
    input wire logic timeout_flag_o,
    input wire logic watchdog_window_violation_flag_o,
    input wire logic software_reset_flag_o,
    input wire logic stack_overflow_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_bor; brownout_i |=> core_reset_o && !brownout_reset_flag_o; endproperty
    a_bor: assert property (p_bor) else $error("brownout not taken");
    property p_lp; low_power_brownout_i && low_power_brownout_cfg_i && !cfg_erased_i
        |=> core_reset_o && !brownout_reset_flag_o; endproperty
    a_lp: assert property (p_lp) else $error("low power brownout not taken");
    // even with the timer off the start delay keeps reset up this long
    property p_hold; $fell(brownout_i) |-> core_reset_o [*8]; endproperty
    a_hold: assert property (p_hold) else $error("reset released early");
    property p_oe; !ext_pin_oe_o; endproperty
    a_oe: assert property (p_oe) else $error("pin driven");
    property p_pin; (ext_reset_pin_enable_i || low_voltage_program_enable_i) [*3]
        |-> !ext_pin_gpio_o && ext_pin_pullup_o; endproperty
    a_pin: assert property (p_pin) else $error("pin function wrong");
    property p_wdt; watchdog_timeout_i |=> core_reset_o && !timeout_flag_o; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog timeout not taken");
    property p_wv; watchdog_window_viol_i |=> core_reset_o && !watchdog_window_violation_flag_o; endproperty
    a_wv: assert property (p_wv) else $error("window violation not taken");
    property p_ri; software_reset_instr_i |=> core_reset_o && !software_reset_flag_o; endproperty
    a_ri: assert property (p_ri) else $error("software reset not taken");
    property p_stk; stack_overflow_i && stack_fault_reset_enable_i
        |=> core_reset_o && stack_overflow_flag_o; endproperty
    a_stk: assert property (p_stk) else $error("stack overflow not taken");
endmodule
bind rss_reset_sequencer rss_reset_sequencer_asserts i_rss_reset_sequencer_asserts (.*);
`default_nettype wire

//--- test/rss_pin_drv.sv
// outside circuit on the active-low external reset pin
`timescale 1ns/1ps
`default_nettype none
module rss_pin_drv (
    input  wire logic clk_i,
    input  wire logic hold_low_i,
    output var  logic pin_o
);
    // released pin rests at the weak pull-up level, never at the last value
    initial pin_o = 1'b1;
    always @(posedge clk_i) pin_o <= !hold_low_i;
endmodule
`default_nettype wire

//--- test/rss_reset_sequencer_tb.sv
// self-checking bench for the reset source sequencer
`timescale 1ns/1ps
`default_nettype none
module rss_reset_sequencer_tb;
    localparam logic [15:0] PUT = 16'h0010;
    logic clk_i = 0, rst_i = 1, por_i = 0, brownout_i = 0, low_power_brownout_i = 0, cfg_erased_i = 0;
    logic [1:0] brownout_enable_setting_i = 2'h0;
    logic low_power_brownout_cfg_i = 0, ext_reset_pin_i, hold_low = 0, gpio_pullup_sw_i = 0;
    logic ext_reset_pin_enable_i = 1, low_voltage_program_enable_i = 0, sleep_instr_i = 0;
    logic watchdog_timeout_i = 0, watchdog_window_viol_i = 0, watchdog_clear_instr_i = 0;
    logic software_reset_instr_i = 0, stack_overflow_i = 0, stack_underflow_i = 0;
    logic stack_fault_reset_enable_i = 0, prog_mode_exit_i = 0, powerup_timer_enable_n_i = 0;
    logic brownout_flag_clr_i = 0, software_reset_flag_set_i = 0, stack_flags_clr_i = 0, window_flag_set_i = 0;
    logic core_reset_o, ext_pin_oe_o, ext_pin_pullup_o, ext_pin_gpio_o, low_power_brownout_config_ok_o;
    logic brownout_reset_flag_o, timeout_flag_o, powerdown_flag_o, watchdog_window_violation_flag_o;
    logic software_reset_flag_o, stack_overflow_flag_o, stack_underflow_flag_o;
    int mismatches = 0;
    int comparisons = 0;

    rss_reset_sequencer #(.PUT_CYCLES(PUT)) i_rss_reset_sequencer (.*);
    rss_pin_drv i_rss_pin_drv (.clk_i(clk_i), .hold_low_i(hold_low), .pin_o(ext_reset_pin_i));

    initial forever #5 clk_i = ~clk_i;

    task automatic chk(string n, logic e, logic g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
    endtask

    // cycles until the core leaves reset, capped so a hang cannot stall us
    task automatic run_in(output int t);
        t = 0;
        while (core_reset_o !== 1'b0 && t < 300) begin
            cyc(1);
            t++;
        end
    endtask

    function automatic int lo(logic d);
        return d ? 10 : PUT + 10;
    endfunction

    function automatic logic cfg_ok(logic [1:0] s, logic er);
        return er || s == 2'h0 || s == 2'h2;
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        int t;
        void'($urandom(32'hdeac5bf1));
        cyc(12);
        rst_i = 0;
        chk("rst_flags", 1, &{timeout_flag_o, powerdown_flag_o, software_reset_flag_o, ~brownout_reset_flag_o});
        run_in(t);
        chk("por_start", 1, t >= lo(0) && t <= lo(0) + 8);
        for (int d = 0; d < 2; d++) begin
            powerup_timer_enable_n_i = d[0];
            pulse(brownout_flag_clr_i);
            pulse(prog_mode_exit_i);
            chk("pm_flag", 0, brownout_reset_flag_o);
            run_in(t);
            chk("pm_start", 1, t >= lo(d[0]) && t <= lo(d[0]) + 8);
        end
        powerup_timer_enable_n_i = 0;
        hold_low = 1;
        pulse(por_i);
        cyc(PUT + 20);
        chk("pin_hold", 1, core_reset_o);
        hold_low = 0;
        cyc(10);
        chk("pin_early", 1, core_reset_o);
        run_in(t);
        chk("pin_late", 1, t <= 10);
        for (int k = 0; k < 8; k++) begin
            hold_low = 1;
            cyc($urandom_range(1, 3));
            hold_low = 0;
            cyc(12);
            chk("glitch", 0, core_reset_o);
        end
        for (int c = 0; c < 4; c++) begin
            ext_reset_pin_enable_i = c[0];
            low_voltage_program_enable_i = c[1];
            gpio_pullup_sw_i = $urandom;
            hold_low = 1;
            cyc(12);
            chk("gpio", !(c[0] | c[1]), ext_pin_gpio_o);
            chk("pullup", c[0] | c[1] | gpio_pullup_sw_i, ext_pin_pullup_o);
            chk("pin_rst", c[0] | c[1], core_reset_o);
            hold_low = 0;
            run_in(t);
        end
        ext_reset_pin_enable_i = 1;
        low_voltage_program_enable_i = 0;
        low_power_brownout_cfg_i = 1;
        for (int c = 0; c < 8; c++) begin
            brownout_enable_setting_i = c[1:0];
            cfg_erased_i = c[2];
            pulse(brownout_flag_clr_i);
            chk("lp_cfg", cfg_ok(c[1:0], c[2]), low_power_brownout_config_ok_o);
            pulse(low_power_brownout_i);
            chk("lp_rst", !c[2], core_reset_o);
            chk("lp_flag", c[2], brownout_reset_flag_o);
            run_in(t);
        end
        low_power_brownout_cfg_i = 0;
        pulse(brownout_i);
        chk("bor", 1, core_reset_o & ~brownout_reset_flag_o);
        run_in(t);
        pulse(watchdog_clear_instr_i);
        chk("clr_flags", 1, timeout_flag_o & powerdown_flag_o);
        pulse(sleep_instr_i);
        chk("sleep_pd", 0, powerdown_flag_o);
        chk("sleep_to", 1, timeout_flag_o);
        pulse(watchdog_timeout_i);
        chk("wdt", 1, core_reset_o & ~timeout_flag_o);
        run_in(t);
        pulse(watchdog_window_viol_i);
        chk("wv", 0, watchdog_window_violation_flag_o);
        run_in(t);
        pulse(window_flag_set_i);
        chk("wv_set", 1, watchdog_window_violation_flag_o);
        pulse(software_reset_instr_i);
        chk("ri", 1, core_reset_o & ~software_reset_flag_o);
        run_in(t);
        pulse(software_reset_flag_set_i);
        chk("ri_set", 1, software_reset_flag_o);
        for (int e = 0; e < 2; e++) begin
            stack_fault_reset_enable_i = e[0];
            pulse(stack_overflow_i);
            chk("ovf", e[0], stack_overflow_flag_o & core_reset_o);
            run_in(t);
            pulse(stack_underflow_i);
            chk("unf", e[0], stack_underflow_flag_o & core_reset_o);
            run_in(t);
            pulse(stack_flags_clr_i);
        end
        chk("oe", 0, ext_pin_oe_o);
        tally_and_finish();
    end
endmodule
`default_nettype wire
